// File: rtl/sdb_pkg.sv
// Package for the serial debug status and breakpoint register block
package sdb_pkg;
    // Status/control bit positions
    localparam int BIT_HALT_PERMIT   = 7;
    localparam int BIT_HALT_ACTIVE   = 6;
    localparam int BIT_HW_BP_ENABLE  = 5;
    localparam int BIT_FORCE_TAG     = 4;
    localparam int BIT_LINK_CLK_SEL  = 3;
    localparam int BIT_WAIT_STOP     = 2;
    localparam int BIT_WS_FAIL       = 1;
    localparam int BIT_SLOW_FAIL     = 0;
    localparam int BIT_FORCE_RESET   = 0;

    localparam logic [7:0]  FORCE_RESET_READ = 8'h00;
    localparam logic [15:0] BP_ADDR_RESET    = 16'h0000;

    // Serial command strobes as delivered by the link decoder
    typedef struct packed {
        logic        status_rd;
        logic        control_wr;
        logic        bp_rd;
        logic        bp_wr;
        logic        force_reset_wr;
        logic [15:0] wdata;
    } sdb_cmd_t;

    // CPU core status and address bus
    typedef struct packed {
        logic        halted;
        logic        in_wait_stop;
        logic        addr_valid;
        logic        opcode_fetch;
        logic [15:0] addr;
        logic        mem_cmd_fail;
        logic        user_force_reset_wr;
        logic [7:0]  user_wdata;
    } sdb_cpu_t;

    typedef enum logic [0:0] {
        SDB_RUN    = 1'b0,
        SDB_HALTED = 1'b1
    } sdb_mode_t;
endpackage : sdb_pkg

// File: rtl/sdb_regs.sv
// Serial debug controller status, control and breakpoint registers
// Operation
// - Halt entry refused while halt_permit is 0; other serial commands still run.
// - halt_permit stays 1 once set until a normal reset.
// - halt_active_flag is read-only, 1 while CPU halted.
// - hw_bp_enable 0 disables breakpoint, ignoring select and address.
// - Force select: address match forces halt at next instruction boundary.
// - Tag select: match tags opcode; halt only if it reaches queue end.
// - link_clock_select resets to 0 (alternate clock); 1 selects bus clock.
// - wait_stop_flag 1 in wait/stop or after halt from wait/stop.
// - wait_stop_fail_flag sets when memory command fails from wait/stop.
// - slow_access_fail_flag exists but always reads 0.
// - Halt command pulls CPU out of wait/stop into halt mode.
// - Status/control register reached only by serial status/control commands.
// - 16-bit breakpoint address, serial access only, invisible to programs.
// - Force-reset register ignores user writes, reads always 0x00.
// - Serial write of 1 to bit 0 forces full device reset.
// - halt_permit writes blocked while CPU already halted.
// - The four status bits are never changed by control writes.
`timescale 1ns/100ps
`default_nettype none
module sdb_regs (
    input  wire logic              sys_clk_in,
    input  wire logic              srst_in,
    input  wire sdb_pkg::sdb_cmd_t cmd_in,
    input  wire logic              halt_cmd_in,
    input  wire sdb_pkg::sdb_cpu_t cpu_in,
    input  wire logic              tagged_at_queue_end_in,
    output logic [7:0]             status_rdata_out,
    output logic [15:0]            bp_rdata_out,
    output logic [7:0]             force_reset_rdata_out,
    output logic                   halt_request_out,
    output logic                   tag_opcode_out,
    output logic                   force_halt_out,
    output logic                   swi_request_out,
    output logic                   link_clock_select_out,
    output logic                   device_reset_out
);
    // Control bits written by the serial control command
    logic               halt_permit_r;
    logic               halt_permit_nxt;
    logic               hw_bp_enable_r;
    logic               hw_bp_enable_nxt;
    logic               force_or_tag_select_r;
    logic               force_or_tag_select_nxt;
    logic               link_clock_select_r;
    logic               link_clock_select_nxt;

    // Breakpoint address and its readback copy
    logic [15:0]        bp_addr_r;
    logic [15:0]        bp_addr_nxt;
    logic [15:0]        bp_rdata_r;
    logic [15:0]        bp_rdata_nxt;

    // Core status flags
    logic               wait_stop_flag_r;
    logic               wait_stop_flag_nxt;
    logic               wait_stop_fail_flag_r;
    logic               wait_stop_fail_flag_nxt;

    // Pending breakpoint and reset requests
    logic               force_halt_r;
    logic               force_halt_nxt;
    logic               device_reset_r;
    logic               device_reset_nxt;

    // Status snapshot
    logic [7:0]         status_live;
    logic [7:0]         status_rdata_r;
    logic [7:0]         status_rdata_nxt;

    // Core mode as seen one cycle late
    sdb_pkg::sdb_mode_t mode_r;
    sdb_pkg::sdb_mode_t mode_nxt;

    logic               bp_match;
    logic               stop_request;

    // Breakpoint compare is gated by enable so select and address are moot
    assign bp_match = hw_bp_enable_r
                      & cpu_in.addr_valid
                      & (cpu_in.addr == bp_addr_r);

    always_comb begin
        halt_permit_nxt         = halt_permit_r;
        hw_bp_enable_nxt        = hw_bp_enable_r;
        force_or_tag_select_nxt = force_or_tag_select_r;
        link_clock_select_nxt   = link_clock_select_r;
        if (cmd_in.control_wr) begin
            // Permit bit frozen while halted to avoid forbidding the current mode
            if (!cpu_in.halted) begin
                // Only a normal reset can drop it once set
                halt_permit_nxt = halt_permit_r
                                  | cmd_in.wdata[sdb_pkg::BIT_HALT_PERMIT];
            end
            hw_bp_enable_nxt        = cmd_in.wdata[sdb_pkg::BIT_HW_BP_ENABLE];
            force_or_tag_select_nxt = cmd_in.wdata[sdb_pkg::BIT_FORCE_TAG];
            link_clock_select_nxt   = cmd_in.wdata[sdb_pkg::BIT_LINK_CLK_SEL];
            // Status bits take no part in a control write
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            halt_permit_r         <= 1'b0;
            hw_bp_enable_r        <= 1'b0;
            force_or_tag_select_r <= 1'b0;
            link_clock_select_r   <= 1'b0;
        end else begin
            halt_permit_r         <= halt_permit_nxt;
            hw_bp_enable_r        <= hw_bp_enable_nxt;
            force_or_tag_select_r <= force_or_tag_select_nxt;
            link_clock_select_r   <= link_clock_select_nxt;
        end
    end

    // Breakpoint address: one 16-bit strobe, no CPU path at all
    always_comb begin
        bp_addr_nxt  = bp_addr_r;
        bp_rdata_nxt = bp_rdata_r;
        if (cmd_in.bp_wr) begin
            bp_addr_nxt = cmd_in.wdata;
        end
        if (cmd_in.bp_rd) begin
            bp_rdata_nxt = bp_addr_r;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bp_addr_r  <= sdb_pkg::BP_ADDR_RESET;
            bp_rdata_r <= sdb_pkg::BP_ADDR_RESET;
        end else begin
            bp_addr_r  <= bp_addr_nxt;
            bp_rdata_r <= bp_rdata_nxt;
        end
    end

    always_comb begin
        wait_stop_fail_flag_nxt = wait_stop_fail_flag_r;
        wait_stop_flag_nxt      = wait_stop_flag_r;
        // Failure flag: set wins; cleared by a status read while halted so the retry starts clean
        if (cpu_in.mem_cmd_fail) begin
            wait_stop_fail_flag_nxt = 1'b1;
        end else if (cmd_in.status_rd && cpu_in.halted) begin
            wait_stop_fail_flag_nxt = 1'b0;
        end
        // Wait/stop flag sticks through a halt that left wait/stop
        if (cpu_in.in_wait_stop) begin
            wait_stop_flag_nxt = 1'b1;
        end else if (cpu_in.halted) begin
            wait_stop_flag_nxt = wait_stop_flag_r;
        end else begin
            wait_stop_flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            wait_stop_flag_r      <= 1'b0;
            wait_stop_fail_flag_r <= 1'b0;
        end else begin
            wait_stop_flag_r      <= wait_stop_flag_nxt;
            wait_stop_fail_flag_r <= wait_stop_fail_flag_nxt;
        end
    end

    always_comb begin
        force_halt_nxt = force_halt_r;
        // Force-type match held until the core reaches its boundary and halts, or until hw_bp_enable is 0
        if (bp_match && force_or_tag_select_r) begin
            force_halt_nxt = 1'b1;
        end else if (cpu_in.halted || !hw_bp_enable_r) begin
            force_halt_nxt = 1'b0;
        end
        // Nothing kept between writes; a zero bit simply yields no pulse
        device_reset_nxt = cmd_in.force_reset_wr
                           & cmd_in.wdata[sdb_pkg::BIT_FORCE_RESET];
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            force_halt_r   <= 1'b0;
            device_reset_r <= 1'b0;
        end else begin
            force_halt_r   <= force_halt_nxt;
            device_reset_r <= device_reset_nxt;
        end
    end

    // Live status; halted state comes straight from the core
    assign status_live = {halt_permit_r,
                          cpu_in.halted,
                          hw_bp_enable_r,
                          force_or_tag_select_r,
                          link_clock_select_r,
                          wait_stop_flag_r,
                          wait_stop_fail_flag_r,
                          1'b0};

    // One capture per status bit, loaded only by a status read
    for (genvar i = 0; i < $bits(status_live); i++) begin : g_status_bit
        assign status_rdata_nxt[i] = cmd_in.status_rd ? status_live[i]
                                                      : status_rdata_r[i];
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            status_rdata_r <= '0;
        end else begin
            status_rdata_r <= status_rdata_nxt;
        end
    end

    // Mode lags the core by a cycle, so a request drops once halt is seen
    always_comb begin
        if (cpu_in.halted) begin
            mode_nxt = sdb_pkg::SDB_HALTED;
        end else begin
            mode_nxt = sdb_pkg::SDB_RUN;
        end
        case (mode_r)
            sdb_pkg::SDB_RUN: begin
                stop_request = 1'b1;
            end
            sdb_pkg::SDB_HALTED: begin
                stop_request = 1'b0;
            end
            default: begin
                stop_request = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mode_r <= sdb_pkg::SDB_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Tag on a match during an opcode fetch; halt only when the tag retires
    assign tag_opcode_out = bp_match
                            & ~force_or_tag_select_r
                            & cpu_in.opcode_fetch;

    // Halt sources, all refused when not permitted; halt command also exits wait/stop
    assign halt_request_out = halt_permit_r
                              & stop_request
                              & (halt_cmd_in
                                 | force_halt_r
                                 | tagged_at_queue_end_in);

    // Without permission a breakpoint falls back to a software interrupt
    assign swi_request_out = ~halt_permit_r
                             & stop_request
                             & (force_halt_r
                                | tagged_at_queue_end_in);

    assign force_halt_out        = force_halt_r;
    assign link_clock_select_out = link_clock_select_r;
    assign device_reset_out      = device_reset_r;
    assign status_rdata_out      = status_rdata_r;
    assign bp_rdata_out          = bp_rdata_r;

    // User writes never reach here; reads are fixed
    assign force_reset_rdata_out = sdb_pkg::FORCE_RESET_READ;
endmodule : sdb_regs
`default_nettype wire

// File: test/sdb_regs_props.sv
// Checker for the debug status and breakpoint registers
`timescale 1ns/100ps
`default_nettype none
module sdb_regs_props (
    input wire logic              sys_clk_in,
    input wire logic              srst_in,
    input wire sdb_pkg::sdb_cmd_t cmd_in,
    input wire logic              halt_cmd_in,
    input wire sdb_pkg::sdb_cpu_t cpu_in,
    input wire logic              tagged_at_queue_end_in,
    input wire logic              swi_request_out,
    input wire logic [7:0]        status_rdata_out,
    input wire logic [15:0]       bp_rdata_out,
    input wire logic [7:0]        force_reset_rdata_out,
    input wire logic              halt_request_out,
    input wire logic              tag_opcode_out,
    input wire logic              force_halt_out,
    input wire logic              link_clock_select_out,
    input wire logic              device_reset_out
);
    logic        pm_r, pm_nxt;
    logic [2:0]  ctl_r, ctl_nxt;
    logic [15:0] bp_r, bp_nxt;
    always_comb begin
        pm_nxt  = pm_r | (cmd_in.control_wr & ~cpu_in.halted & cmd_in.wdata[7]);
        ctl_nxt = cmd_in.control_wr ? cmd_in.wdata[5:3] : ctl_r;
        bp_nxt  = cmd_in.bp_wr ? cmd_in.wdata : bp_r;
    end
    always_ff @(posedge sys_clk_in) begin
        pm_r  <= srst_in ? 1'b0 : pm_nxt;
        ctl_r <= srst_in ? 3'h0 : ctl_nxt;
        bp_r  <= srst_in ? sdb_pkg::BP_ADDR_RESET : bp_nxt;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    permit_gate_a: assert property (halt_request_out |-> pm_r)
        else $error("halt request without permit");
    halt_cmd_a: assert property (halt_cmd_in && pm_r && !$past(cpu_in.halted)
        |-> halt_request_out) else $error("halt command not passed on");
    status_snap_a: assert property (cmd_in.status_rd |=>
        {status_rdata_out[7], status_rdata_out[5:3], status_rdata_out[0]}
        == {$past(pm_r), $past(ctl_r), 1'b0}) else $error("status snapshot wrong");
    bp_read_a: assert property (cmd_in.bp_rd |=> bp_rdata_out == $past(bp_r))
        else $error("breakpoint readback wrong");
    fr_read_a: assert property (force_reset_rdata_out == sdb_pkg::FORCE_RESET_READ)
        else $error("force reset reads nonzero");
    reset_pulse_a: assert property (cmd_in.force_reset_wr && cmd_in.wdata[0]
        |=> device_reset_out) else $error("no device reset");
    clk_sel_a: assert property (link_clock_select_out == ctl_r[0])
        else $error("clock select wrong");
    tag_match_a: assert property (tag_opcode_out |-> ctl_r[2] && !ctl_r[1] &&
        cpu_in.opcode_fetch && cpu_in.addr == bp_r) else $error("bad opcode tag");
    force_bp_a: assert property (pm_r && ctl_r == 3'h6 && cpu_in.addr_valid &&
        cpu_in.addr == bp_r && !cpu_in.halted |=> force_halt_out) else $error("no force");
    swi_gate_a: assert property (swi_request_out |-> !pm_r)
        else $error("software interrupt while permitted");
    halt_flag_a: assert property (cmd_in.status_rd |=>
        status_rdata_out[6] == $past(cpu_in.halted)) else $error("halt flag wrong");
    cover property (cmd_in.status_rd);
    cover property (tag_opcode_out);
    cover property (device_reset_out);
    cover property (force_halt_out);
endmodule : sdb_regs_props
bind sdb_regs sdb_regs_props u_sdb_regs_props (.sys_clk_in, .srst_in, .cmd_in,
    .halt_cmd_in, .cpu_in, .tagged_at_queue_end_in, .swi_request_out,
    .status_rdata_out, .bp_rdata_out, .force_reset_rdata_out,
    .halt_request_out, .tag_opcode_out, .force_halt_out, .link_clock_select_out,
    .device_reset_out);
`default_nettype wire

// File: test/sdb_host.sv
// Debug host model: serial command strobes and halt command
`timescale 1ns/100ps
`default_nettype none
module sdb_host (
    input  wire logic        sys_clk_in,
    output var sdb_pkg::sdb_cmd_t cmd_out,
    output var logic              halt_out
);
    initial begin
        cmd_out  = '0;
        halt_out = 1'b0;
    end
    // Released data inverted so stale data never looks valid
    task automatic send(input logic [4:0] s, input logic [15:0] d);
        @(posedge sys_clk_in);
        cmd_out <= {s, d};
        @(posedge sys_clk_in);
        cmd_out <= {5'h00, ~d};
    endtask : send
    task automatic halt_now();
        @(posedge sys_clk_in);
        halt_out <= 1'b1;
        @(posedge sys_clk_in);
        halt_out <= 1'b0;
    endtask : halt_now
endmodule : sdb_host
`default_nettype wire

// File: test/sdb_regs_bench.sv
// Bench for the debug status and breakpoint registers
`timescale 1ns/100ps
`default_nettype none
module sdb_regs_bench;
    logic              sys_clk_in, srst_in, tqe, halt, hreq, tag, fh, clks, drst;
    sdb_pkg::sdb_cpu_t cpu;
    sdb_pkg::sdb_cmd_t cmd;
    logic [7:0]        st, fr;
    logic [15:0]       bp, bpq;
    logic [15:0]       cw [2] = '{16'h0020, 16'h0010};
    int                errors, comparisons, seed;
    sdb_host u_sdb_host (.sys_clk_in, .cmd_out(cmd), .halt_out(halt));
    sdb_regs u_sdb_regs (.sys_clk_in, .srst_in, .cmd_in(cmd), .halt_cmd_in(halt),
        .cpu_in(cpu), .tagged_at_queue_end_in(tqe), .status_rdata_out(st),
        .bp_rdata_out(bpq), .force_reset_rdata_out(fr), .halt_request_out(hreq),
        .tag_opcode_out(tag), .force_halt_out(fh), .swi_request_out(),
        .link_clock_select_out(clks), .device_reset_out(drst));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // Core model halts on the edge that sees a request
    always @(posedge sys_clk_in) if (hreq) cpu.halted <= 1'b1;
    function automatic logic [7:0] exp_st(input logic p, h, input logic [2:0] c,
        input logic w, f);
        return {p, h, c, w, f, 1'b0};
    endfunction : exp_st
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rds(input logic [7:0] e);
        u_sdb_host.send(5'h10, 16'h0000);
        #1 chk("status", {8'h00, e}, {8'h00, st});
    endtask : rds
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        errors++;
        complete_run();
    end
    initial begin
        seed = 5809;
        srst_in = 1'b1;
        cpu = '0;
        tqe = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        rds(exp_st(0, 0, 3'h0, 0, 0));
        u_sdb_host.send(5'h08, 16'h00ff);
        rds(exp_st(1, 0, 3'h7, 0, 0));
        chk("clksel", 1, clks);
        u_sdb_host.halt_now();
        rds(exp_st(1, 1, 3'h7, 0, 0));
        u_sdb_host.send(5'h08, 16'h0030);
        bp = 16'($random(seed));
        u_sdb_host.send(5'h02, bp);
        u_sdb_host.send(5'h04, 16'h0000);
        #1 chk("bp", bp, bpq);
        rds(exp_st(1, 1, 3'h6, 0, 0));
        @(posedge sys_clk_in);
        cpu.halted <= 1'b0;
        cpu.addr_valid <= 1'b1;
        cpu.addr <= bp;
        @(posedge sys_clk_in);
        #1 chk("force", 1, fh);
        foreach (cw[k]) begin
            u_sdb_host.send(5'h08, cw[k]);
            for (int i = 0; i < 20; i++) begin
                @(posedge sys_clk_in);
                cpu.opcode_fetch <= 1'b1;
                cpu.addr <= (i % 4 == 0) ? bp : 16'($random(seed));
                #1 chk("tag", k == 0 && cpu.addr === bp, tag);
                chk("fh", 0, fh);
            end
        end
        cpu.halted <= 1'b0;
        @(posedge sys_clk_in);
        tqe <= 1'b1;
        #1 chk("tag_halt", 1, hreq);
        @(posedge sys_clk_in);
        tqe <= 1'b0;
        cpu.in_wait_stop <= 1'b1;
        cpu.mem_cmd_fail <= 1'b1;
        cpu.user_force_reset_wr <= 1'b1;
        cpu.user_wdata <= 8'hff;
        @(posedge sys_clk_in);
        cpu.mem_cmd_fail <= 1'b0;
        rds(exp_st(1, 1, 3'h2, 1, 1));
        u_sdb_host.halt_now();
        rds(exp_st(1, 1, 3'h2, 1, 0));
        u_sdb_host.send(5'h01, 16'h00fe);
        #1 chk("rst0", 0, drst);
        u_sdb_host.send(5'h01, 16'h0001);
        #1 chk("rst1", 1, drst);
        chk("frd", 0, fr);
        // Second reset with the core already halted: permit must not set
        srst_in <= 1'b1;
        cpu.in_wait_stop <= 1'b0;
        cpu.halted <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        u_sdb_host.send(5'h08, 16'h0080);
        rds(exp_st(0, 1, 3'h0, 0, 0));
        complete_run();
    end
endmodule : sdb_regs_bench
`default_nettype wire
